// file: design/haptic_regs.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * haptic state and mode controller.
 * Assumes a 125 MHz system clock and a 32-bit Avalon-MM register port.
 */
`ifndef HAPTIC_REGS_SVH
`define HAPTIC_REGS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_HZ            125000000
`define STANDBY_WAKE_US   150
`define IDLE_WAKE_US      750
`define STANDBY_WAKE_CYC  (`STANDBY_WAKE_US * (`CLK_HZ / 1000000))
`define IDLE_WAKE_CYC     (`IDLE_WAKE_US * (`CLK_HZ / 1000000))
`define WAKE_CNT_W        17
`define PWM_FREQ_HZ       187500
`define PWM_PERIOD_CYC    (`CLK_HZ / `PWM_FREQ_HZ)
`define PWM_CNT_W         10

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define REG_CTRL          8'h00
`define REG_TRIGGER       8'h04
`define REG_STREAM        8'h08
`define REG_GPI_CFG       8'h0C
`define REG_FAULT         8'h10
`define REG_STATUS        8'h14
`define REG_SUPPLY        8'h18

// ****************************************************************
// Fields
// ****************************************************************
`define CTRL_W            11
`define CTRL_MODE_MSB     2
`define CTRL_MODE_LSB     0
`define CTRL_STANDBY_BIT  3
`define CTRL_CLOSED_BIT   4
`define CTRL_FEAT_MSB     8
`define CTRL_FEAT_LSB     5
`define CTRL_ACCEL_BIT    6
`define CTRL_SHAPE_MSB    10
`define CTRL_SHAPE_LSB    9
`define TRIG_START_BIT    0
`define TRIG_STOP_BIT     1
`define FAULT_SHORT_BIT   0
`define FAULT_EXT_BIT     1
`define MODE_MAX          3'h4
`define LEVEL_MAX_POS     8'h7F
`define LEVEL_MAX_NEG     8'h80
`define WAVE_SINE         2'h0
`define WAVE_SQUARE       2'h1

// ****************************************************************
// Reset values
// ****************************************************************
`define CTRL_RST          11'h000
`define STREAM_RST        8'h00
`define GPI_CFG_RST       6'h00

`endif

// file: design/haptic_pkg.sv
/*
 * Types shared by the haptic state and mode controller and its helpers.
 * Assumes nothing of its surroundings.
 */
package haptic_pkg;

   typedef enum logic [2:0] {
      ST_BOOT,
      ST_IDLE,
      ST_STANDBY,
      ST_WAKE,
      ST_DRIVE
   } fsm_state_t;

   typedef enum logic [2:0] {
      MODE_INACTIVE,
      MODE_REGISTER_STREAMED,
      MODE_PWM_STREAMED,
      MODE_REGISTER_TRIGGERED,
      MODE_EDGE_TRIGGERED
   } play_mode_t;

endpackage

// file: design/edge_trigger_detect.sv
/*
 * Edge events on the three general inputs, each with its own polarity:
 * 0 rising, 1 falling, 2 both, 3 none.
 * Assumes the pins are synchronous to sys_clk.
 */
`timescale 1ns/100ps
`default_nettype none
module edge_trigger_detect
   import haptic_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       arst_n,
   input  wire logic [2:0] pins,
   input  wire logic [5:0] polarity,
   output var  logic [2:0] events,
   output var  logic       rise_zero
);
   import haptic_pkg::*;

   typedef struct packed {
      logic [2:0] prev;
      logic [2:0] evt;
      logic       rise0;
   } edge_t;

   edge_t s_q;
   edge_t s_d;

   always_comb begin
      s_d = s_q;
      for (int i = 0; i < 3; i++) begin
         unique case (polarity[2*i +: 2])
            2'h0: s_d.evt[i] = pins[i] & ~s_q.prev[i];
            2'h1: s_d.evt[i] = ~pins[i] & s_q.prev[i];
            2'h2: s_d.evt[i] = pins[i] ^ s_q.prev[i];
            2'h3: s_d.evt[i] = 1'b0;
         endcase
      end
      s_d.rise0 = pins[0] & ~s_q.prev[0];
      s_d.prev  = pins;
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign events    = s_q.evt;
   assign rise_zero = s_q.rise0;

   property p_rise_event;
      @(posedge sys_clk) disable iff (!arst_n)
         (polarity[1:0] == 2'h0) && pins[0] && !s_q.prev[0] |=> events[0];
   endproperty
   a_rise_event: assert property (p_rise_event) // R11
      else $error("rising edge on pin zero gave no event");

endmodule
`default_nettype wire

// file: design/pwm_carrier.sv
/*
 * Fixed-frequency output carrier: a free counter of one switching period and
 * a duty compare against a 7-bit magnitude.
 * Assumes the magnitude is steady or changes only between periods.
 */
`timescale 1ns/100ps
`default_nettype none
`include "haptic_regs.svh"
module pwm_carrier
   import haptic_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       arst_n,
   input  wire logic [6:0] magnitude,
   output var  logic       carrier
);
   import haptic_pkg::*;

   localparam logic [`PWM_CNT_W-1:0] LAST = `PWM_CNT_W'(`PWM_PERIOD_CYC - 1);

   typedef struct packed {
      logic [`PWM_CNT_W-1:0] cnt;
      logic                  out;
   } pwm_t;

   pwm_t        s_q;
   pwm_t        s_d;
   logic [16:0] lhs;
   logic [16:0] rhs;

   // Duty = magnitude/127 of the period, no divider needed
   always_comb begin
      s_d = s_q;
      lhs = 17'(s_q.cnt) * 17'h0007F;
      rhs = 17'(magnitude) * 17'(`PWM_PERIOD_CYC);
      s_d.cnt = (s_q.cnt == LAST) ? '0 : s_q.cnt + 1'b1; // R18
      s_d.out = lhs < rhs;
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign carrier = s_q.out;

   property p_period_wrap;
      @(posedge sys_clk) disable iff (!arst_n)
         s_q.cnt == LAST |=> s_q.cnt == '0 ##1 s_q.cnt == 10'h001;
   endproperty
   a_period_wrap: assert property (p_period_wrap) // R18
      else $error("switching period counter did not wrap");

endmodule
`default_nettype wire

// file: design/haptic_state_mode_control.sv
/*
 * State and playback-mode controller of the actuator driver with its
 * Avalon-MM register slave, wake timing and H-bridge output gating.
 * Assumes synchronous pins, a fault detector and a waveform engine outside
 * that report short_detect, fault_detect and seq_done as one-cycle pulses.
 */
// Design decisions made here: the register addresses and the Avalon-MM interface to the registers.
// How it works
// R1: Reset loads defaults, boot, then idle
// R2: Any playback request leads into drive
// R3: Playback end returns to standby or idle
// R4: Any fault forces idle directly
// R5: Start only on request with faults cleared
// R6: Registers kept in idle and standby
// R7: Mode 0 plays nothing, waits idle/standby
// R8: Mode 1 drives the streamed level register
// R9: Mode 2 streams from general input zero
// R10: Mode 3 plays on trigger bit only
// R11: Mode 4 plays on pin edges or trigger
// R12: Output within 0.15 ms standby, 0.75 ms idle
// R13: Output short puts bridge in high impedance
// R14: Open loop disables back-EMF monitoring and adjustment
// R15: Closed loop enables features one by one
// R16: Open loop drives configured wave, sine default
// R17: Supply limits drive, supply readable
// R18: Output switching at fixed 187.5 kHz; the code uses a 666-cycle period of 125 MHz, about 187.69 kHz
// R19: Enable low fully resets everything
// R20: Pin or bus activity wakes; bus always usable
// R21: Mode above 4 treated as inactive
`timescale 1ns/100ps
`default_nettype none
`include "haptic_regs.svh"
module haptic_state_mode_control
   import haptic_pkg::*;
#(
   parameter int unsigned STANDBY_WAKE_CYC = `STANDBY_WAKE_CYC,
   parameter int unsigned IDLE_WAKE_CYC    = `IDLE_WAKE_CYC
)(
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output var  logic [31:0] avs_readdata,
   output var  logic        avs_waitrequest,
   input  wire logic        general_input_zero,
   input  wire logic        general_input_one,
   input  wire logic        general_input_two,
   input  wire logic        seq_done,
   input  wire logic        short_detect,
   input  wire logic        fault_detect,
   input  wire logic [7:0]  supply_level,
   output var  logic        output_positive_pin,
   output var  logic        output_positive_pin_oe_n,
   output var  logic        output_negative_pin,
   output var  logic        output_negative_pin_oe_n,
   output var  logic        bemf_monitor_en,
   output var  logic [3:0]  feature_active,
   output var  logic [1:0]  wave_shape,
   output var  logic [6:0]  drive_magnitude,
   output var  logic [2:0]  device_state
);
   import haptic_pkg::*;

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      fsm_state_t              state;
      logic [`WAKE_CNT_W-1:0]  wake_cnt;
      logic                    waitreq;
      logic [31:0]             rdata;
      logic [`CTRL_W-1:0]      ctrl;
      logic [7:0]              level;
      logic [5:0]              gpi_pol;
      logic [1:0]              fault;
      logic [7:0]              supply;
      logic [6:0]              mag;
      logic                    neg;
      logic                    out_p;
      logic                    out_n;
      logic                    oe_n;
      logic                    bemf;
      logic [3:0]              feat;
      logic [1:0]              shape;
   } ctl_t;

   ctl_t        s_q;
   ctl_t        s_d;

   logic [2:0]  gpi_evt;
   logic        gpi_rise0;
   logic        carrier;
   logic        acc;
   logic        wr;
   logic [31:0] wmerge;
   logic        trig;
   logic        stop;
   logic        stream_wr;
   logic        request;
   logic        done;
   logic        fault_new;
   logic        closed;
   logic        accel;
   logic        drive_on;
   logic [7:0]  src_level;
   play_mode_t  mode_eff;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  be);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return r;
   endfunction

   // Magnitude of a two's complement level, capped by half the supply code
   function automatic logic [6:0] clamp_mag(input logic [7:0] lvl,
                                            input logic [7:0] sup);
      logic [7:0] m;
      logic [6:0] cap;
      m   = lvl[7] ? (8'h00 - lvl) : lvl;
      cap = sup[7:1];
      if (m > 8'(cap)) begin
         m = 8'(cap);
      end
      return m[6:0];
   endfunction

   // ****************************************************************
   // Submodules
   // ****************************************************************
   edge_trigger_detect u_edges (
      .sys_clk   (sys_clk),
      .arst_n    (arst_n),
      .pins      ({general_input_two, general_input_one, general_input_zero}),
      .polarity  (s_q.gpi_pol),
      .events    (gpi_evt),
      .rise_zero (gpi_rise0)
   );

   pwm_carrier u_pwm (
      .sys_clk   (sys_clk),
      .arst_n    (arst_n),
      .magnitude (s_q.mag),
      .carrier   (carrier)
   );

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      s_d       = s_q;
      acc       = (avs_read | avs_write) & ~s_q.waitreq;
      wr        = acc & avs_write;
      wmerge    = 32'h0000_0000;
      trig      = 1'b0;
      stop      = 1'b0;
      stream_wr = 1'b0;
      request   = 1'b0;
      done      = 1'b0;
      src_level = 8'h00;

      // Bus slave: one wait cycle, then the accept cycle; works in every state
      if ((avs_read | avs_write) && s_q.waitreq) begin // R20
         s_d.waitreq = 1'b0;
         unique case (avs_address)
            `REG_CTRL:    s_d.rdata = 32'(s_q.ctrl);
            `REG_STREAM:  s_d.rdata = 32'(s_q.level);
            `REG_GPI_CFG: s_d.rdata = 32'(s_q.gpi_pol);
            `REG_FAULT:   s_d.rdata = 32'(s_q.fault);
            `REG_STATUS:  s_d.rdata = {21'h000000, s_q.shape, s_q.feat, s_q.bemf,
                                       s_q.oe_n, 3'(s_q.state)};
            `REG_SUPPLY:  s_d.rdata = {17'h00000, s_q.mag, s_q.supply}; // R17
            default:      s_d.rdata = 32'h0000_0000;
         endcase
      end
      if (acc) begin
         s_d.waitreq = 1'b1;
      end

      // Register writes; values persist through idle and standby
      if (wr) begin // R6
         unique case (avs_address)
            `REG_CTRL: begin
               wmerge     = be_merge(32'(s_q.ctrl), avs_writedata, avs_byteenable);
               s_d.ctrl   = wmerge[`CTRL_W-1:0];
            end
            `REG_TRIGGER: begin
               trig = avs_byteenable[0] & avs_writedata[`TRIG_START_BIT];
               stop = avs_byteenable[0] & avs_writedata[`TRIG_STOP_BIT];
            end
            `REG_STREAM: begin
               wmerge    = be_merge(32'(s_q.level), avs_writedata, avs_byteenable);
               s_d.level = wmerge[7:0];
               stream_wr = avs_byteenable[0];
            end
            `REG_GPI_CFG: begin
               wmerge      = be_merge(32'(s_q.gpi_pol), avs_writedata, avs_byteenable);
               s_d.gpi_pol = wmerge[5:0];
            end
            default: begin
            end
         endcase
      end

      // Sticky faults, write one to clear, a new fault wins over the clear
      fault_new = short_detect | fault_detect;
      if (wr && avs_address == `REG_FAULT && avs_byteenable[0]) begin
         s_d.fault = s_q.fault & ~avs_writedata[1:0];
      end
      s_d.fault[`FAULT_SHORT_BIT] = s_d.fault[`FAULT_SHORT_BIT] | short_detect;
      s_d.fault[`FAULT_EXT_BIT]   = s_d.fault[`FAULT_EXT_BIT] | fault_detect;

      s_d.supply = supply_level; // R17

      // Playback mode decode
      if (s_q.ctrl[`CTRL_MODE_MSB:`CTRL_MODE_LSB] > `MODE_MAX) begin
         mode_eff = MODE_INACTIVE; // R21
      end else begin
         mode_eff = play_mode_t'(s_q.ctrl[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
      end
      closed = s_q.ctrl[`CTRL_CLOSED_BIT];
      accel  = s_q.ctrl[`CTRL_ACCEL_BIT];

      unique case (mode_eff)
         MODE_INACTIVE: begin
            request = 1'b0; // R7
            done    = 1'b1;
         end
         MODE_REGISTER_STREAMED: begin
            request   = stream_wr; // R8
            done      = stop;
            src_level = (accel && s_q.level[7]) ? 8'h00 : s_q.level;
         end
         MODE_PWM_STREAMED: begin
            request   = gpi_rise0; // R9
            done      = stop;
            src_level = general_input_zero ? `LEVEL_MAX_POS :
                        (accel ? 8'h00 : `LEVEL_MAX_NEG);
         end
         MODE_REGISTER_TRIGGERED: begin
            request   = trig; // R10
            done      = seq_done | stop;
            src_level = `LEVEL_MAX_POS;
         end
         MODE_EDGE_TRIGGERED: begin
            request   = trig | (|gpi_evt); // R11
            done      = seq_done | stop;
            src_level = `LEVEL_MAX_POS;
         end
         default: begin
            request = 1'b0;
            done    = 1'b1;
         end
      endcase

      // System states
      unique case (s_q.state)
         ST_BOOT: begin
            s_d.state = ST_IDLE; // R1
         end
         ST_IDLE, ST_STANDBY: begin
            if (fault_new) begin
               s_d.state = ST_IDLE; // R4
            end else if (request && s_q.fault == 2'h0) begin // R5
               s_d.state    = ST_WAKE; // R2
               s_d.wake_cnt = (s_q.state == ST_STANDBY) ?
                              `WAKE_CNT_W'(STANDBY_WAKE_CYC - 1) :
                              `WAKE_CNT_W'(IDLE_WAKE_CYC - 1); // R12
            end else if (mode_eff == MODE_INACTIVE) begin
               s_d.state = s_q.ctrl[`CTRL_STANDBY_BIT] ? ST_STANDBY : ST_IDLE; // R7
            end
         end
         ST_WAKE: begin
            if (fault_new) begin
               s_d.state = ST_IDLE; // R4
            end else if (done) begin
               s_d.state = s_q.ctrl[`CTRL_STANDBY_BIT] ? ST_STANDBY : ST_IDLE; // R3
            end else if (s_q.wake_cnt == '0) begin
               s_d.state = ST_DRIVE; // R12
            end else begin
               s_d.wake_cnt = s_q.wake_cnt - 1'b1;
            end
         end
         ST_DRIVE: begin
            if (fault_new) begin
               s_d.state = ST_IDLE; // R4
            end else if (done) begin
               s_d.state = s_q.ctrl[`CTRL_STANDBY_BIT] ? ST_STANDBY : ST_IDLE; // R3
            end
         end
         default: begin
            s_d.state = ST_IDLE;
         end
      endcase

      // Loop mode: open loop has no back-EMF and no automatic adjustment
      s_d.bemf  = closed; // R14
      s_d.feat  = closed ? s_q.ctrl[`CTRL_FEAT_MSB:`CTRL_FEAT_LSB] : 4'h0; // R15
      s_d.shape = closed ? `WAVE_SQUARE :
                  s_q.ctrl[`CTRL_SHAPE_MSB:`CTRL_SHAPE_LSB]; // R16

      // Drive level limited by the supply
      s_d.mag = clamp_mag(src_level, supply_level); // R17
      s_d.neg = src_level[7];

      // Bridge: driven only in drive, released on a short
      drive_on  = (s_d.state == ST_DRIVE) && !s_d.fault[`FAULT_SHORT_BIT];
      s_d.oe_n  = !drive_on; // R13
      s_d.out_p = drive_on && !s_q.neg && carrier; // R18
      s_d.out_n = drive_on && s_q.neg && carrier;
   end

   // Enable low is the asynchronous reset: every register returns to default
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin // R19
         s_q         <= '0;
         s_q.state   <= ST_BOOT;
         s_q.waitreq <= 1'b1;
         s_q.ctrl    <= `CTRL_RST;
         s_q.level   <= `STREAM_RST;
         s_q.gpi_pol <= `GPI_CFG_RST;
         s_q.shape   <= `WAVE_SINE;
         s_q.oe_n    <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign avs_readdata             = s_q.rdata;
   assign avs_waitrequest          = s_q.waitreq;
   assign output_positive_pin      = s_q.out_p;
   assign output_negative_pin      = s_q.out_n;
   assign output_positive_pin_oe_n = s_q.oe_n;
   assign output_negative_pin_oe_n = s_q.oe_n;
   assign bemf_monitor_en          = s_q.bemf;
   assign feature_active           = s_q.feat;
   assign wave_shape               = s_q.shape;
   assign drive_magnitude          = s_q.mag;
   assign device_state             = 3'(s_q.state);

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_boot_idle;
      @(posedge sys_clk) disable iff (!arst_n)
         s_q.state == ST_BOOT |=> s_q.state == ST_IDLE;
   endproperty
   a_boot_idle: assert property (p_boot_idle) // R1
      else $error("boot did not settle in idle");

   property p_fault_idle;
      @(posedge sys_clk) disable iff (!arst_n)
         fault_new && s_q.state != ST_BOOT |=> s_q.state == ST_IDLE;
   endproperty
   a_fault_idle: assert property (p_fault_idle) // R4
      else $error("fault did not force idle");

   property p_no_start_faulted;
      @(posedge sys_clk) disable iff (!arst_n)
         (s_q.state == ST_IDLE || s_q.state == ST_STANDBY) && s_q.fault != 2'h0
         |=> s_q.state != ST_WAKE;
   endproperty
   a_no_start_faulted: assert property (p_no_start_faulted) // R5
      else $error("playback started with a pending fault");

   property p_return_state;
      @(posedge sys_clk) disable iff (!arst_n)
         s_q.state == ST_DRIVE && done && !fault_new
         |=> s_q.state == ($past(s_q.ctrl[`CTRL_STANDBY_BIT]) ? ST_STANDBY : ST_IDLE);
   endproperty
   a_return_state: assert property (p_return_state) // R3
      else $error("wrong state after playback end");

   property p_standby_latency;
      @(posedge sys_clk) disable iff (!arst_n)
         s_q.state == ST_STANDBY && request && !fault_new && s_q.fault == 2'h0
         |=> s_q.state == ST_WAKE && s_q.wake_cnt == `WAKE_CNT_W'(STANDBY_WAKE_CYC - 1);
   endproperty
   a_standby_latency: assert property (p_standby_latency) // R12
      else $error("standby wake count wrong");

   property p_wake_bound;
      @(posedge sys_clk) disable iff (!arst_n)
         s_q.state == ST_WAKE |-> s_q.wake_cnt < `WAKE_CNT_W'(IDLE_WAKE_CYC);
   endproperty
   a_wake_bound: assert property (p_wake_bound) // R12
      else $error("wake count beyond idle latency");

   property p_bad_mode;
      @(posedge sys_clk) disable iff (!arst_n)
         s_q.ctrl[`CTRL_MODE_MSB:`CTRL_MODE_LSB] > `MODE_MAX && s_q.state == ST_IDLE
         |=> s_q.state != ST_WAKE;
   endproperty
   a_bad_mode: assert property (p_bad_mode) // R21
      else $error("playback in an undefined mode");

   property p_short_hiz;
      @(posedge sys_clk) disable iff (!arst_n)
         short_detect |=> output_positive_pin_oe_n && output_negative_pin_oe_n
                          && !output_positive_pin && !output_negative_pin;
   endproperty
   a_short_hiz: assert property (p_short_hiz) // R13
      else $error("bridge still driven after a short");

   property p_open_loop;
      @(posedge sys_clk) disable iff (!arst_n)
         !s_q.ctrl[`CTRL_CLOSED_BIT] |=> !bemf_monitor_en && feature_active == 4'h0;
   endproperty
   a_open_loop: assert property (p_open_loop) // R14
      else $error("back-EMF features active in open loop");

   property p_drive_only_in_drive;
      @(posedge sys_clk) disable iff (!arst_n)
         !output_positive_pin_oe_n |-> s_q.state == ST_DRIVE;
   endproperty
   a_drive_only_in_drive: assert property (p_drive_only_in_drive) // R2
      else $error("bridge driven outside drive state");

endmodule
`default_nettype wire

// file: dv/host_bus_model.sv
/* Host on the register bus: an Avalon-MM master with one transfer task.
   Assumes a slave that holds waitrequest high until it answers. */
`timescale 1ns/100ps
`default_nettype none
module host_bus_model (
   input  wire logic        sys_clk,
   output var  logic [7:0]  avs_address,
   output var  logic        avs_read,
   output var  logic        avs_write,
   output var  logic [31:0] avs_writedata,
   output var  logic [3:0]  avs_byteenable,
   input  wire logic [31:0] avs_readdata,
   input  wire logic        avs_waitrequest
);
   logic hung = 1'b0;
   initial {avs_address, avs_read, avs_write, avs_writedata, avs_byteenable} = 46'hF;
   // Request held until waitrequest is sampled low or 50 cycles have passed
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      int n;
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      n = 0;
      do @(posedge sys_clk) n++;
      while (avs_waitrequest !== 1'b0 && n < 50);
      hung = avs_waitrequest !== 1'b0;
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
endmodule
`default_nettype wire

// file: dv/tb_haptic_state_mode_control.sv
/* Bench of the state and mode controller: host model on the bus, pins and
   fault inputs driven here. Assumes wake counts shortened to 4 and 8. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(s,e,g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
$display("MISMATCH %s exp %0h got %0h", s, e, g); end end
module tb_haptic_state_mode_control;
   import haptic_pkg::*;
   logic        sys_clk = 0, arst_n = 0, seq_done = 0, short_detect = 0, fault_detect = 0;
   logic        rd, wr, wq, oe_n, bemf, pos_pin, neg_pin, neg_oe_n;
   logic [2:0]  gp = 0, st;
   logic [7:0]  sup = 8'hFF, adr, lv;
   logic [31:0] lf = 32'h371F, wd, rdt, q;
   logic [3:0]  be, feat;
   logic [1:0]  shp;
   logic [6:0]  mag;
   int          miscompares = 0, check_count = 0, n;
   always #4 sys_clk = ~sys_clk;
   host_bus_model host_bus_model_inst (.sys_clk, .avs_address(adr), .avs_read(rd),
      .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdt),
      .avs_waitrequest(wq));
   haptic_state_mode_control #(.STANDBY_WAKE_CYC(4), .IDLE_WAKE_CYC(8))
      haptic_state_mode_control_inst (.sys_clk, .arst_n, .avs_address(adr),
      .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
      .avs_readdata(rdt), .avs_waitrequest(wq), .general_input_zero(gp[0]),
      .general_input_one(gp[1]), .general_input_two(gp[2]), .seq_done,
      .short_detect, .fault_detect, .supply_level(sup), .output_positive_pin(pos_pin),
      .output_positive_pin_oe_n(oe_n), .output_negative_pin(neg_pin),
      .output_negative_pin_oe_n(neg_oe_n), .bemf_monitor_en(bemf), .feature_active(feat),
      .wave_shape(shp), .drive_magnitude(mag), .device_state(st));
   function automatic logic [31:0] lfsr(logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic logic [6:0] emag(logic [7:0] l, logic [7:0] s);
      logic [7:0] m;
      m = l[7] ? -l : l;
      return m[6:0] > s[7:1] ? s[7:1] : m[6:0];
   endfunction
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w = 1);
      host_bus_model_inst.xfer(w, a, d, q);
      if (host_bus_model_inst.hung) begin
         miscompares++;
         give_verdict();
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask
   task automatic await(input logic [2:0] s);
      #1 n = 0;
      while (st !== s && n < 300) @(posedge sys_clk) #1 n++;
      `CHK("state", s, st)
   endtask
   // One-cycle pulse: 0 seq_done, 1 short_detect, 2 fault_detect
   task automatic pulse(input int k);
      @(posedge sys_clk) {fault_detect, short_detect, seq_done} <= 3'(1 << k);
      @(posedge sys_clk) {fault_detect, short_detect, seq_done} <= 3'h0;
   endtask
   initial begin
      repeat (3) @(posedge sys_clk);
      arst_n <= 1'b1;
      await(3'h1);
      bus(8'h00, 32'h0);
      tick(3);
      `CHK("bemf", 1'b0, bemf)
      `CHK("shape", 2'h0, shp)
      lf = lfsr(lf);
      bus(8'h00, {23'h0, lf[3:0], 5'h10});
      tick(3);
      `CHK("feat", lf[3:0], feat)
      bus(8'h0C, 32'h0);
      for (int m = 2; m <= 4; m++) begin
         bus(8'h00, 32'(m));
         @(posedge sys_clk) gp <= 3'h5;
         @(posedge sys_clk) gp <= 3'h0;
         tick(12);
         `CHK("pin", m == 3 ? 3'h1 : 3'h4, st)
         if (m == 3) begin
            bus(8'h04, 32'h1);
            await(3'h4);
            `CHK("wake", 8, n)
         end
         `CHK("oe", 1'b0, oe_n)
         if (m == 2) bus(8'h04, 32'h2);
         else pulse(0);
         await(3'h1);
      end
      bus(8'h00, 32'h8);
      await(3'h2);
      bus(8'h00, 32'hB);
      bus(8'h04, 32'h1);
      await(3'h4);
      `CHK("wake", 4, n)
      pulse(0);
      await(3'h2);
      bus(8'h04, 32'h1);
      await(3'h4);
      pulse(1);
      await(3'h1);
      `CHK("fault", 1'b1, n <= 2)
      `CHK("hiz", 1'b1, oe_n)
      `CHK("hiz2", 3'h4, {neg_oe_n, pos_pin, neg_pin})
      bus(8'h04, 32'h1);
      tick(12);
      `CHK("held", 3'h1, st)
      bus(8'h10, 32'h3);
      pulse(2);
      bus(8'h10, 32'h3);
      bus(8'h04, 32'h1);
      await(3'h4);
      pulse(0);
      await(3'h2);
      bus(8'h00, 32'h5);
      bus(8'h04, 32'h1);
      tick(12);
      `CHK("mode5", 3'h1, st)
      bus(8'h00, 32'h1);
      repeat (4) begin
         lf = lfsr(lf);
         lv = lf[7] ? lf[7:0] | 8'h1 : lf[7:0];
         @(posedge sys_clk) sup <= lf[15:8];
         bus(8'h08, {24'h0, lv});
         await(3'h4);
         tick(4);
         `CHK("mag", emag(lv, sup), mag)
      end
      bus(8'h18, 32'h0, 1'b0);
      `CHK("supply", sup, q[7:0])
      bus(8'h04, 32'h2);
      await(3'h1);
      bus(8'h08, 32'h0, 1'b0);
      `CHK("kept", lv, q[7:0])
      give_verdict();
   end
endmodule
`default_nettype wire
